// file: rtl/csu_defs.vh
// constants for the compare-and-skip unit
// assumes a 16-bit instruction word and an 8-bit data path
`ifndef CSU_DEFS_VH
`define CSU_DEFS_VH

// instruction fields: opcode in the upper seven bits, then bank bit and address byte
`define CSU_OPC_MSB        15
`define CSU_OPC_LSB        9
`define CSU_OPC_GT         7'h32
`define CSU_OPC_LT         7'h30
`define CSU_BANKSEL_BIT    8
`define CSU_FADDR_MSB      7
`define CSU_FADDR_LSB      0

// fixed access bank split
`define CSU_ACCESS_SPLIT   8'h80
`define CSU_ACCESS_LO_BANK 4'h0
`define CSU_ACCESS_HI_BANK 4'hF

// quarter phases of one instruction cycle
`define CSU_Q1             2'h0
`define CSU_Q2             2'h1
`define CSU_Q3             2'h2
`define CSU_Q4             2'h3

// no-operation cycles after a skip
`define CSU_SKIP_ONE       2'h1
`define CSU_SKIP_TWO       2'h2

`endif

// file: rtl/csu_qphase.v
// quarter-phase counter of the instruction cycle
// assumes one clock; rst_b synchronous, active low
`timescale 1ns/10ps
`include "csu_defs.vh"

module csu_qphase (
   input  wire       sys_clk,
   input  wire       rst_b,
   output reg  [1:0] phase_reg
);

   ////////////////////////////////////////////////////////////////////////////
   // four-phase count, wraps Q4 to Q1
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         phase_reg <= `CSU_Q1;
      end else begin
         phase_reg <= phase_reg + 2'h1;
      end
   end

endmodule // csu_qphase

// file: rtl/csu_top.v
// compare-and-skip instruction decoder and executor
// assumes fetch, data memory and accumulator on the same sys_clk
// Operation
// - decode greater-than compare-skip: fixed upper seven bits, bank bit, address byte
// - decode less-than compare-skip: fixed upper seven bits, bank bit, address byte
// - unsigned subtract accumulator from byte; operands and flags untouched
// - greater variant: byte above accumulator discards fetched instruction, runs nop
// - less variant: byte below accumulator discards fetched instruction, runs nop
// - bank bit clear: address resolved in fixed access bank, bank pointer ignored
// - bank bit set: address resolved in bank held by bank pointer
// - one word; one cycle without skip, two cycles with skip
// - skipped two-word instruction: three cycles, both words become nop cycles
`timescale 1ns/10ps
`include "csu_defs.vh"

module csu_top (
   input  wire        sys_clk,
   input  wire        rst_b,
   input  wire [15:0] instr_word,
   input  wire        instr_valid,
   input  wire        next_is_two_word,
   input  wire [7:0]  accumulator_register,
   input  wire [3:0]  bank_pointer_register,
   input  wire [7:0]  mem_rd_data,
   output reg  [11:0] mem_rd_addr_reg,
   output reg         mem_rd_en_reg,
   output reg         flush_reg,
   output reg         nop_exec_reg,
   output reg         busy_reg,
   output reg         cmp_true_reg,
   output reg         done_reg
);

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_EXEC = 2'h1;
   localparam [1:0] ST_SKIP = 2'h2;

   wire [1:0]  phase;
   reg  [1:0]  state_reg;
   reg         op_gt_reg;
   reg  [7:0]  operand_reg;
   reg  [1:0]  skip_left_reg;
   wire [6:0]  opc;
   wire        is_gt;
   wire        is_lt;
   wire [7:0]  faddr;
   wire        banksel;
   reg  [3:0]  bank_sel;
   wire [8:0]  diff;
   wire        borrow;
   wire        nonzero;
   wire        cond_true;
   wire        at_q1;
   wire        at_q2;
   wire        at_q3;
   wire        at_q4;
   wire        start;
   wire        last_nop;

   // next values of the registers
   reg  [1:0]  state_next;
   reg         op_gt_next;
   reg  [7:0]  operand_next;
   reg  [1:0]  skip_left_next;
   reg  [11:0] mem_rd_addr_next;
   reg         mem_rd_en_next;
   reg         flush_next;
   reg         nop_exec_next;
   reg         busy_next;
   reg         cmp_true_next;
   reg         done_next;

   ////////////////////////////////////////////////////////////////////////////
   // phase source
   csu_qphase u_qphase (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .phase_reg (phase)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decode
   assign opc     = instr_word[`CSU_OPC_MSB:`CSU_OPC_LSB];
   assign is_gt   = (opc == `CSU_OPC_GT);
   assign is_lt   = (opc == `CSU_OPC_LT);
   assign faddr   = instr_word[`CSU_FADDR_MSB:`CSU_FADDR_LSB];
   assign banksel = instr_word[`CSU_BANKSEL_BIT];

   // bank resolution
   always @* begin
      if (banksel) begin
         bank_sel = bank_pointer_register;
      end else if (faddr < `CSU_ACCESS_SPLIT) begin
         bank_sel = `CSU_ACCESS_LO_BANK;
      end else begin
         bank_sel = `CSU_ACCESS_HI_BANK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // unsigned compare, nothing written back
   assign diff    = {1'b0, operand_reg} - {1'b0, accumulator_register};
   assign borrow  = diff[8];
   assign nonzero = (diff[7:0] != 8'h00);
   assign cond_true = op_gt_reg ? (!borrow && nonzero)
                                : borrow;

   ////////////////////////////////////////////////////////////////////////////
   // quarter strobes of the instruction cycle
   assign at_q1 = (phase == `CSU_Q1);
   assign at_q2 = (phase == `CSU_Q2);
   assign at_q3 = (phase == `CSU_Q3);
   assign at_q4 = (phase == `CSU_Q4);

   ////////////////////////////////////////////////////////////////////////////
   // accept a word only at the decode quarter of an idle cycle
   assign start    = (state_reg == ST_IDLE) && at_q1 && instr_valid
                     && (is_gt || is_lt);
   assign last_nop = (skip_left_reg == `CSU_SKIP_ONE);

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic; words arriving while busy are ignored
   always @* begin
      state_next       = state_reg;
      op_gt_next       = op_gt_reg;
      operand_next     = operand_reg;
      skip_left_next   = skip_left_reg;
      mem_rd_addr_next = mem_rd_addr_reg;
      mem_rd_en_next   = 1'b0;
      flush_next       = 1'b0;
      nop_exec_next    = nop_exec_reg;
      busy_next        = busy_reg;
      cmp_true_next    = cmp_true_reg;
      done_next        = 1'b0;

      case (state_reg)
         ST_IDLE: begin
            // first quarter decodes, second reads the operand
            if (start) begin
               op_gt_next       = is_gt;
               mem_rd_addr_next = {bank_sel, faddr};
               mem_rd_en_next   = 1'b1;
               busy_next        = 1'b1;
               cmp_true_next    = 1'b0;
               state_next       = ST_EXEC;
            end
         end

         ST_EXEC: begin
            if (at_q2) begin
               operand_next = mem_rd_data;
            end else if (at_q3) begin
               cmp_true_next = cond_true;
            end else if (at_q4) begin
               // no write-back; skip decision leaves the cycle
               if (cmp_true_reg) begin
                  flush_next     = 1'b1;
                  nop_exec_next  = 1'b1;
                  skip_left_next = next_is_two_word ? `CSU_SKIP_TWO
                                                    : `CSU_SKIP_ONE;
                  state_next     = ST_SKIP;
               end else begin
                  busy_next  = 1'b0;
                  done_next  = 1'b1;
                  state_next = ST_IDLE;
               end
            end
         end

         ST_SKIP: begin
            // each nop cycle ends at its fourth quarter
            if (at_q4) begin
               if (last_nop) begin
                  nop_exec_next = 1'b0;
                  busy_next     = 1'b0;
                  done_next     = 1'b1;
                  cmp_true_next = 1'b0;
                  state_next    = ST_IDLE;
               end else begin
                  flush_next = 1'b1;
               end
               skip_left_next = skip_left_reg - 2'h1;
            end
         end

         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state and output registers
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         state_reg       <= ST_IDLE;
         op_gt_reg       <= 1'b0;
         operand_reg     <= 8'h00;
         skip_left_reg   <= 2'h0;
         mem_rd_addr_reg <= 12'h000;
         mem_rd_en_reg   <= 1'b0;
         flush_reg       <= 1'b0;
         nop_exec_reg    <= 1'b0;
         busy_reg        <= 1'b0;
         cmp_true_reg    <= 1'b0;
         done_reg        <= 1'b0;
      end else begin
         state_reg       <= state_next;
         op_gt_reg       <= op_gt_next;
         operand_reg     <= operand_next;
         skip_left_reg   <= skip_left_next;
         mem_rd_addr_reg <= mem_rd_addr_next;
         mem_rd_en_reg   <= mem_rd_en_next;
         flush_reg       <= flush_next;
         nop_exec_reg    <= nop_exec_next;
         busy_reg        <= busy_next;
         cmp_true_reg    <= cmp_true_next;
         done_reg        <= done_next;
      end
   end

endmodule // csu_top

// file: tb/csu_checker.sv
// assertions for the compare-and-skip unit
// assumes the bench holds inputs steady through an instruction
`timescale 1ns/10ps
module csu_checker (
   input wire        sys_clk,
   input wire        rst_b,
   input wire [15:0] instr_word,
   input wire        next_is_two_word,
   input wire [7:0]  accumulator_register,
   input wire [3:0]  bank_pointer_register,
   input wire [7:0]  mem_rd_data,
   input wire [11:0] mem_rd_addr_reg,
   input wire        mem_rd_en_reg,
   input wire        flush_reg,
   input wire        nop_exec_reg,
   input wire        busy_reg,
   input wire        cmp_true_reg,
   input wire        done_reg
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   wire [7:0] f = instr_word[7:0];
   ////////////////////////////////////////////////////////////////////////////////
   rd_pulse_a: assert property (mem_rd_en_reg |-> busy_reg ##1 !mem_rd_en_reg)
      else $error("read pulse wrong");
   addr_bank_a: assert property (mem_rd_en_reg |-> mem_rd_addr_reg ==
      (instr_word[8] ? {bank_pointer_register, f} : {{4{f[7]}}, f})) else $error("bad address");
   gt_cmp_a: assert property (mem_rd_en_reg && instr_word[10] |->
      ##2 cmp_true_reg == (mem_rd_data > accumulator_register)) else $error("gt wrong");
   lt_cmp_a: assert property (mem_rd_en_reg && !instr_word[10] |->
      ##2 cmp_true_reg == (mem_rd_data < accumulator_register)) else $error("lt wrong");
   no_skip_a: assert property (mem_rd_en_reg ##2 !cmp_true_reg |=>
      done_reg && !flush_reg && !busy_reg) else $error("plain end wrong");
   skip_one_a: assert property (mem_rd_en_reg ##2
      (cmp_true_reg && !next_is_two_word) |=> flush_reg && nop_exec_reg
      ##4 done_reg && !nop_exec_reg) else $error("skip wrong");
   skip_two_a: assert property (mem_rd_en_reg ##2
      (cmp_true_reg && next_is_two_word) |=> flush_reg ##4 flush_reg ##4 done_reg)
      else $error("double skip wrong");
   nop_busy_a: assert property (nop_exec_reg |-> busy_reg && !mem_rd_en_reg)
      else $error("nop without busy");
   done_pulse_a: assert property (done_reg |=> !done_reg)
      else $error("done too long");
   cover property (flush_reg ##4 flush_reg);
   cover property (mem_rd_en_reg ##2 !cmp_true_reg);
   cover property (nop_exec_reg ##1 done_reg);
endmodule // csu_checker
bind csu_top csu_checker csu_checker_i (.*);

// file: tb/csu_top_tb.sv
// self-checking bench for the compare-and-skip unit
// assumes csu_top and the bound checker
`timescale 1ns/10ps
module csu_top_tb;
   logic        sys_clk = 1'b0, rst_b = 1'b0, vld = 1'b0, two = 1'b0;
   logic [15:0] ins = 16'h0000;
   logic [7:0]  acc = 8'h00, md = 8'h00;
   logic [3:0]  bp = 4'h0;
   wire  [11:0] addr;
   wire         rd_en, flush, nop, busy, cmp, done;
   int          fails = 0, n_compared = 0, cyc = 0;
   always #25 sys_clk = ~sys_clk;
   csu_top csu_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .instr_word(ins), .instr_valid(vld),
      .next_is_two_word(two), .accumulator_register(acc), .bank_pointer_register(bp),
      .mem_rd_data(md), .mem_rd_addr_reg(addr), .mem_rd_en_reg(rd_en), .flush_reg(flush),
      .nop_exec_reg(nop), .busy_reg(busy), .cmp_true_reg(cmp), .done_reg(done));
   ////////////////////////////////////////////////////////////////////////////////
   function logic [11:0] exp_addr(input [15:0] w, input [3:0] b);
      return w[8] ? {b, w[7:0]} : {{4{w[7]}}, w[7:0]};
   endfunction
   task chk(input string nm, input logic [11:0] e, g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task close_out;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic go(input [15:0] w, input [7:0] a, m, input [3:0] b, input t);
      int n = 0, fl = 0, nn = 0;
      logic [11:0] ad = 12'h000;
      logic ct = 1'b0;
      logic sk = w[10] ? m > a : m < a;
      ins = w;
      acc = a;
      md = m;
      bp = b;
      two = t;
      vld = 1'b1;
      do begin
         @(negedge sys_clk);
         n++;
         if (rd_en === 1'b1) ad = addr;
         if (n == 3) ct = cmp;
         if (flush === 1'b1) fl++;
         if (nop === 1'b1) nn++;
      end while (done !== 1'b1 && n < 20);
      chk("address", exp_addr(w, b), ad);
      chk("compare", sk, ct);
      chk("cycles", 12'(sk ? (t ? 12 : 8) : 4), 12'(n));
      chk("flushes", 12'(sk ? (t ? 2 : 1) : 0), 12'(fl));
      chk("nop cycles", 12'(sk ? (t ? 8 : 4) : 0), 12'(nn));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         close_out;
      end
   end
   initial begin
      void'($urandom(32'hAE2F));
      repeat (16) @(negedge sys_clk);
      rst_b = 1'b1;
      ins = 16'h6600;
      vld = 1'b1;
      repeat (8) begin
         @(negedge sys_clk);
         chk("ignored", 12'h000, {rd_en, busy});
         if (vld) begin
            ins = 16'h6480;
            vld = 1'b0;
         end
      end
      go(16'h6480, 8'h00, 8'hFF, 4'h5, 1'b1);
      go(16'h617F, 8'h55, 8'h55, 4'hA, 1'b0);
      go(16'h607F, 8'hFF, 8'h00, 4'h3, 1'b0);
      go(16'h6500, 8'h01, 8'h00, 4'h3, 1'b0);
      ins = 16'h6400;
      acc = 8'h00;
      md = 8'hFF;
      two = 1'b0;
      repeat (6) @(negedge sys_clk);
      chk("skip nop", 12'h001, {11'h000, nop});
      rst_b = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("reset", 12'h000, {rd_en, busy, flush, nop, cmp, done});
      rst_b = 1'b1;
      repeat (40)
         go({5'h0C, 1'($urandom), 1'b0, 9'($urandom)}, 8'($urandom), 8'($urandom),
            4'($urandom), 1'($urandom));
      vld = 1'b0;
      close_out;
   end
endmodule // csu_top_tb
